// [core/wdt_regs.vh]
// Constants for the watchdog timer unit: field positions, reset values, timing.
// Definitions only; included by the prescaler and the watchdog timer unit design files.
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// Reset control register bit positions
`define WDT_RESET_CONTROL_REGISTER_SWEN_BIT 5
`define WDT_RESET_CONTROL_REGISTER_TO_BIT 4
`define WDT_RESET_CONTROL_REGISTER_SLEEP_BIT 3
`define WDT_RESET_CONTROL_REGISTER_IDLE_BIT 2

// Config word field positions
`define WDT_CFG_POST_LSB 0
`define WDT_CFG_POST_MSB 3
`define WDT_CFG_PRE_BIT 4
`define WDT_CFG_WINDOW_DISABLE_BIT 6
`define WDT_CFG_FEN_BIT 7

// Prescale ratios
`define WDT_PRE_SMALL 8'h20
`define WDT_PRE_LARGE 8'h80

// Reset values
`define WDT_FLAG_RESET 1'b0
`define WDT_SWEN_RESET 1'b0

// Nominal low-power clock in Hz and system clock in Hz
`define WDT_LOW_POWER_RC_OSC_HZ 32000
`define WDT_CLK_HZ 20000000
// Core-clock cycles per low-power tick (rounded down)
`define WDT_TICK_CYCLES (`WDT_CLK_HZ / `WDT_LOW_POWER_RC_OSC_HZ)

`endif

// [core/wdt_prescaler.v]
// Prescaler: divides the low-power tick stream by 32 or 128.
// Assumes tickIn is a one-cycle pulse in the core clock domain.
`timescale 1ns/1ps
`include "wdt_regs.vh"
module wdt_prescaler (
	input wire clk,
	input wire nrst,
	input wire ce,
	input wire clear,
	input wire run,
	input wire divLarge,
	input wire tickIn,
	output reg tickOut
);
	reg [7:0] cnt_r;
	wire [7:0] lastVal;
	assign lastVal = divLarge ? (`WDT_PRE_LARGE - 8'h01) : (`WDT_PRE_SMALL - 8'h01);
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 8'h00;
			tickOut <= 1'b0;
		end else if (ce) begin
			tickOut <= 1'b0;
			if (clear || !run) begin
				cnt_r <= 8'h00;
			end else if (tickIn) begin
				if (cnt_r >= lastVal) begin
					cnt_r <= 8'h00;
					tickOut <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
		end
	end
endmodule // wdt_prescaler

// [core/wdt_postscaler.v]
// Postscaler: counts prescaler ticks to 2^sel and flags the time-out.
// Assumes tickIn is a one-cycle pulse; timeout is a one-cycle pulse.
`timescale 1ns/1ps
module wdt_postscaler #(
	parameter WIDTH = 16
) (
	input wire clk,
	input wire nrst,
	input wire ce,
	input wire clear,
	input wire run,
	input wire [3:0] sel,
	input wire tickIn,
	output reg timeout,
	output reg [WIDTH-1:0] count
);
	wire [WIDTH-1:0] lastVal;
	assign lastVal = ({{(WIDTH-1){1'b0}}, 1'b1} << sel) - {{(WIDTH-1){1'b0}}, 1'b1};
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= {WIDTH{1'b0}};
			timeout <= 1'b0;
		end else if (ce) begin
			timeout <= 1'b0;
			if (clear || !run) begin
				count <= {WIDTH{1'b0}};
			end else if (tickIn) begin
				if (count >= lastVal) begin
					count <= {WIDTH{1'b0}};
					timeout <= 1'b1;
				end else begin
					count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // wdt_postscaler

// [core/watchdog_timer_unit.v]
// Watchdog timer unit: tick generator, prescaler, postscaler, enable,
// clear events, time-out flag, wake and reset requests, window check.
// Assumes CPU event strobes are one-cycle pulses on clk; config bits static.
`timescale 1ns/1ps
`include "wdt_regs.vh"
module watchdog_timer_unit #(
	parameter TICK_CYCLES = `WDT_TICK_CYCLES,
	parameter POST_WIDTH = 16
) (
	input wire clk,
	input wire nrst,
	input wire ce,
	// Configuration word bits
	input wire [3:0] postscaleSelect,
	input wire prescaleSelect,
	input wire windowDisable,
	input wire fixedWatchdogEnable,
	input wire [1:0] windowSelect,
	// Software enable bit write
	input wire softwareEnableWr,
	input wire softwareEnableIn,
	// Flag clear strobe from software
	input wire timeoutFlagClr,
	// CPU event strobes and the sleepOrIdle level
	input wire clearWatchdogInstruction,
	input wire powerSaveInstruction,
	input wire powerSaveExit,
	input wire clockSwitchDone,
	input wire sleepOrIdle,
	// Status and requests
	output reg softwareWatchdogEnable,
	output reg watchdogTimeoutFlag,
	output reg wakeRequest,
	output reg resetRequest,
	output reg windowViolation,
	output wire lowPowerRcOscEnable,
	output wire watchdogActive,
	output reg [POST_WIDTH-1:0] postCount
);
	////////////////////////////////////////////////////////////////////
	// Enable
	wire enabled;
	assign enabled = fixedWatchdogEnable | softwareWatchdogEnable;
	assign watchdogActive = enabled;
	assign lowPowerRcOscEnable = enabled;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			softwareWatchdogEnable <= `WDT_SWEN_RESET;
		end else if (ce && softwareEnableWr) begin
			softwareWatchdogEnable <= softwareEnableIn;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Clear events
	wire windowed;
	wire earlyClear;
	wire clrCounts;
	wire postTimeout;
	wire [POST_WIDTH-1:0] postCountW;
	reg [POST_WIDTH-1:0] windowOpen;
	wire [POST_WIDTH-1:0] periodLen;
	assign windowed = ~windowDisable;
	assign periodLen = {{(POST_WIDTH-1){1'b0}}, 1'b1} << postscaleSelect;

	// Window opens at 75/50/37.5/25 percent of the period for select 0..3; always open when postscaleSelect is below 3
	always @* begin
		windowOpen = {POST_WIDTH{1'b0}};
		if (postscaleSelect >= 4'h3) begin
			case (windowSelect)
			// Sums of shifts keep the width; a product would widen to 32 bits
			2'b00: windowOpen = (periodLen >> 1) + (periodLen >> 2);
			2'b01: windowOpen = periodLen >> 1;
			2'b10: windowOpen = (periodLen >> 2) + (periodLen >> 3);
			default: windowOpen = periodLen >> 2;
			endcase
		end
	end

	// Only in normal running does the instruction clear or get checked
	assign earlyClear = windowed && enabled && clearWatchdogInstruction && !sleepOrIdle
		&& (postCountW < windowOpen);
	assign clrCounts = (clearWatchdogInstruction && !sleepOrIdle)
		| powerSaveInstruction
		| powerSaveExit
		| clockSwitchDone;

	////////////////////////////////////////////////////////////////////
	// Low-power tick stands in for the RC oscillator edge
	reg [15:0] tickCnt_r;
	reg tick_r;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tickCnt_r <= 16'h0000;
			tick_r <= 1'b0;
		end else if (ce) begin
			tick_r <= 1'b0;
			if (!enabled) begin
				tickCnt_r <= 16'h0000;
			end else if (tickCnt_r >= TICK_CYCLES[15:0] - 16'h0001) begin
				tickCnt_r <= 16'h0000;
				tick_r <= 1'b1;
			end else begin
				tickCnt_r <= tickCnt_r + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Divider chain; runs regardless of sleep state
	wire preTick;
	wdt_prescaler u_pre (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.clear(clrCounts),
		.run(enabled),
		.divLarge(prescaleSelect),
		.tickIn(tick_r),
		.tickOut(preTick)
	);

	wdt_postscaler #(.WIDTH(POST_WIDTH)) u_post (
		.clk(clk),
		.nrst(nrst),
		.ce(ce),
		.clear(clrCounts),
		.run(enabled),
		.sel(postscaleSelect),
		.tickIn(preTick),
		.timeout(postTimeout),
		.count(postCountW)
	);

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			postCount <= {POST_WIDTH{1'b0}};
		end else if (ce) begin
			postCount <= postCountW;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Flag and requests
	wire tmo;
	assign tmo = postTimeout && enabled;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			watchdogTimeoutFlag <= `WDT_FLAG_RESET;
			wakeRequest <= 1'b0;
			resetRequest <= 1'b0;
			windowViolation <= 1'b0;
		end else if (ce) begin
			// Set wins over a coincident software clear
			if (tmo) begin
				watchdogTimeoutFlag <= 1'b1;
			end else if (timeoutFlagClr) begin
				watchdogTimeoutFlag <= 1'b0;
			end
			wakeRequest <= tmo && sleepOrIdle;
			resetRequest <= (tmo && !sleepOrIdle) || earlyClear;
			windowViolation <= earlyClear;
		end
	end
endmodule // watchdog_timer_unit

// [bench/watchdog_timer_unit_checker.sv]
// Port-level assertions for the watchdog timer unit.
// Assumes one clock, asynchronous active-low reset, bound to the top module.
`timescale 1ns/1ps
module watchdog_timer_unit_checker #(
	parameter POST_WIDTH = 16
) (
	input wire clk,
	input wire nrst,
	input wire ce,
	input wire windowDisable,
	input wire fixedWatchdogEnable,
	input wire timeoutFlagClr,
	input wire clearWatchdogInstruction,
	input wire powerSaveInstruction,
	input wire powerSaveExit,
	input wire clockSwitchDone,
	input wire sleepOrIdle,
	input wire softwareWatchdogEnable,
	input wire watchdogTimeoutFlag,
	input wire wakeRequest,
	input wire resetRequest,
	input wire windowViolation,
	input wire lowPowerRcOscEnable,
	input wire watchdogActive,
	input wire [POST_WIDTH-1:0] postCount
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Clear-watchdog is ignored while asleep, so it is no clear event there
	sequence clrEv;
		ce && (clockSwitchDone || powerSaveInstruction || powerSaveExit
			|| (clearWatchdogInstruction && !sleepOrIdle));
	endsequence
	en_combine_a: assert property (watchdogActive == (fixedWatchdogEnable | softwareWatchdogEnable))
		else $error("enable combine wrong");
	osc_follow_a: assert property (lowPowerRcOscEnable == watchdogActive)
		else $error("oscillator enable wrong");
	count_clear_a: assert property (clrEv |=> ##1 postCount == 0)
		else $error("count not cleared");
	disabled_hold_a: assert property (!watchdogActive [*3] |-> postCount == 0)
		else $error("count moves while disabled");
	flag_sticky_a: assert property ($fell(watchdogTimeoutFlag) |-> $past(timeoutFlagClr))
		else $error("flag fell without clear");
	flag_cause_a: assert property ($rose(watchdogTimeoutFlag) |-> wakeRequest || resetRequest)
		else $error("flag set without time-out");
	wake_pulse_a: assert property (wakeRequest |-> (watchdogTimeoutFlag && !resetRequest) ##1 !wakeRequest)
		else $error("wake pulse wrong");
	run_reset_a: assert property (resetRequest && !windowViolation |-> watchdogTimeoutFlag ##1 !resetRequest)
		else $error("run time-out reset wrong");
	early_clear_a: assert property (windowViolation |-> resetRequest && $past(clearWatchdogInstruction && !windowDisable))
		else $error("window violation wrong");
endmodule // watchdog_timer_unit_checker
bind watchdog_timer_unit watchdog_timer_unit_checker #(.POST_WIDTH(POST_WIDTH)) chk (.*);

// [bench/test_watchdog_timer_unit.sv]
// Self-checking bench for the watchdog timer unit.
// Assumes a shortened tick divider; strobes driven as one-cycle pulses.
`timescale 1ns/1ps
module test_watchdog_timer_unit;
	localparam TC = 2;
	logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, prescaleSelect = 1'b0;
	logic [3:0] postscaleSelect = 4'h0;
	logic [1:0] windowSelect = 2'h0;
	logic windowDisable = 1'b1, fixedWatchdogEnable = 1'b0, sleepOrIdle = 1'b0;
	logic softwareEnableWr = 1'b0, softwareEnableIn = 1'b0, timeoutFlagClr = 1'b0;
	logic clearWatchdogInstruction = 1'b0, powerSaveInstruction = 1'b0;
	logic powerSaveExit = 1'b0, clockSwitchDone = 1'b0;
	wire softwareWatchdogEnable, watchdogTimeoutFlag, wakeRequest, resetRequest;
	wire windowViolation, lowPowerRcOscEnable, watchdogActive;
	wire [15:0] postCount;
	int num_errors = 0, n_compared = 0;
	always #25 clk = ~clk;
	watchdog_timer_unit #(.TICK_CYCLES(TC), .POST_WIDTH(16)) dut (.*);
	////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic strobe(input logic [4:0] v);
		{timeoutFlagClr, clearWatchdogInstruction, powerSaveInstruction,
			powerSaveExit, clockSwitchDone} <= v;
		@(posedge clk);
		{timeoutFlagClr, clearWatchdogInstruction, powerSaveInstruction,
			powerSaveExit, clockSwitchDone} <= 5'h00;
	endtask
	task automatic swEnable(input logic v);
		softwareEnableIn <= v;
		softwareEnableWr <= 1'b1;
		@(posedge clk);
		softwareEnableWr <= 1'b0;
	endtask
	task automatic doReset;
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(negedge clk);
		check(softwareWatchdogEnable, 16'h0000);
		check(postCount, 16'h0000);
		check(watchdogTimeoutFlag, 16'h0000);
		@(posedge clk);
	endtask
	// Leaves the bench at a negedge with the flag seen, or counts a hang
	task automatic waitFlag(input int lo, input int hi);
		int n;
		n = 0;
		while (watchdogTimeoutFlag !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		check(16'(n >= lo && n <= hi), 16'h0001);
	endtask
	task automatic finishTimeout;
		swEnable(1'b0);
		repeat (4) @(posedge clk);
		@(negedge clk);
		check(watchdogTimeoutFlag, 16'h0001);
		@(posedge clk);
		strobe(5'h10);
		@(negedge clk);
		check(watchdogTimeoutFlag, 16'h0000);
		@(posedge clk);
	endtask
	////////////////////////////////////////
	task automatic tPeriod(input logic pre, input logic [3:0] sel, input int exp);
		prescaleSelect <= pre;
		postscaleSelect <= sel;
		swEnable(1'b1);
		waitFlag(exp - 4, exp + 8);
		check(resetRequest, 16'h0001);
		check(wakeRequest, 16'h0000);
		@(posedge clk);
		finishTimeout();
	endtask
	task automatic tSleep;
		postscaleSelect <= 4'h0;
		prescaleSelect <= 1'b0;
		sleepOrIdle <= 1'b1;
		swEnable(1'b1);
		strobe(5'h04);
		strobe(5'h08); // Refused while asleep, count keeps running
		waitFlag(TC * 32 - 5, TC * 32 + 8);
		check(wakeRequest, 16'h0001);
		check(resetRequest, 16'h0000);
		@(posedge clk);
		sleepOrIdle <= 1'b0;
		strobe(5'h02);
		finishTimeout();
	endtask
	task automatic tClears;
		swEnable(1'b1);
		for (int k = 0; k < 4; k++) begin
			repeat (50) @(posedge clk);
			strobe(5'h01 << k);
		end
		@(negedge clk);
		check(watchdogTimeoutFlag, 16'h0000);
		@(posedge clk);
		swEnable(1'b0);
	endtask
	task automatic tWindow;
		windowDisable <= 1'b0;
		postscaleSelect <= 4'h3;
		swEnable(1'b1);
		repeat (3) @(posedge clk);
		strobe(5'h08);
		@(negedge clk);
		check(windowViolation, 16'h0001);
		check(resetRequest, 16'h0001);
		@(posedge clk);
		// Quarter-period window: count 3 of 8 is past the open point
		windowSelect <= 2'h3;
		repeat (200) @(posedge clk);
		strobe(5'h08);
		@(negedge clk);
		check(windowViolation, 16'h0000);
		check(resetRequest, 16'h0000);
		@(posedge clk);
		windowSelect <= 2'h0;
		windowDisable <= 1'b1;
		swEnable(1'b0);
	endtask
	task automatic tEnables;
		fixedWatchdogEnable <= 1'b1;
		swEnable(1'b0);
		@(negedge clk);
		check(watchdogActive, 16'h0001);
		check(lowPowerRcOscEnable, 16'h0001);
		@(posedge clk);
		fixedWatchdogEnable <= 1'b0;
		@(negedge clk);
		check(watchdogActive, 16'h0000);
		@(posedge clk);
		swEnable(1'b1);
		@(negedge clk);
		check(watchdogActive, 16'h0001);
		@(posedge clk);
		doReset();
	endtask
	////////////////////////////////////////
	task automatic summarize;
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#1000000;
		num_errors++;
		summarize();
	end
	initial begin
		@(posedge clk);
		doReset();
		tPeriod(1'b0, 4'h0, TC * 32);
		tPeriod(1'b1, 4'h0, TC * 128);
		tPeriod(1'b0, 4'h2, TC * 32 * 4);
		tSleep();
		tClears();
		tWindow();
		tEnables();
		summarize();
	end
endmodule // test_watchdog_timer_unit
